// file: verilog/load_params.svh
// Constants for the eight-bit load decoder
`ifndef LOAD_PARAMS_SVH
`define LOAD_PARAMS_SVH

`define ELD_T_FETCH     3'h4
`define ELD_T_READ      3'h3
`define ELD_T_WRITE     3'h3
`define ELD_T_CALC      3'h5
`define ELD_PREFIX_ONE  8'hDD
`define ELD_PREFIX_TWO  8'hFD
`define ELD_HALT_CODE   8'h76
`define ELD_MEM_CODE    3'h6
`define ELD_PC_RESET    16'h0000
`define ELD_FLAGS_RESET 8'h00
`define ELD_REG_RESET   8'h00
`define ELD_LEN_COPY    5'h04
`define ELD_LEN_TWO     5'h07
`define ELD_LEN_INDEX   5'h13

`endif

// file: verilog/load_pkg.sv
// Types and decode helpers for the eight-bit load decoder
`include "load_params.svh"

package load_pkg;

    typedef enum logic [1:0] {
        CYC_FETCH,
        CYC_READ,
        CYC_WRITE,
        CYC_CALC
    } cyc_kind_t;

    typedef enum logic [2:0] {
        OPC_COPY,
        OPC_IMM,
        OPC_PTR_RD,
        OPC_PTR_WR,
        OPC_PREFIX,
        OPC_OTHER
    } op_class_t;

    typedef enum {
        PH_BOOT,
        PH_OPCODE,
        PH_PREOP,
        PH_IMM,
        PH_DISP,
        PH_CALC,
        PH_MEMRD,
        PH_MEMWR
    } phase_t;

    // Field bits 5:3 name the destination, 2:0 the source
    function automatic op_class_t op_class(input logic [7:0] op);
        op_class_t c;
        c = OPC_OTHER;
        if (op == `ELD_PREFIX_ONE || op == `ELD_PREFIX_TWO)
            c = OPC_PREFIX;
        else if (op == `ELD_HALT_CODE)
            c = OPC_OTHER;
        else if (op[7:6] == 2'h1)
        begin
            if (op[2:0] == `ELD_MEM_CODE)
                c = OPC_PTR_RD;
            else if (op[5:3] == `ELD_MEM_CODE)
                c = OPC_PTR_WR;
            else
                c = OPC_COPY;
        end
        else if (op[7:6] == 2'h0 && op[2:0] == `ELD_MEM_CODE && op[5:3] != `ELD_MEM_CODE)
            c = OPC_IMM;
        return c;
    endfunction : op_class

    // Displacement is two's complement; the sum wraps in 16 bits
    function automatic logic [15:0] eff_addr(input logic [15:0] base, input logic [7:0] d);
        return base + {{8{d[7]}}, d};
    endfunction : eff_addr

endpackage : load_pkg

// file: verilog/mcyc_if.sv
// Machine cycle request channel between decoder and cycle unit
`timescale 1ns/1ns
`default_nettype none

interface mcyc_if;
    logic                start;
    load_pkg::cyc_kind_t kind;
    logic [2:0]          len;
    logic [15:0]         addr;
    logic [7:0]          wdata;
    logic                last;
    logic [7:0]          rdata;

    modport ctrl (output start, kind, len, addr, wdata, input last, rdata);
    modport unit (input start, kind, len, addr, wdata, output last, rdata);
endinterface : mcyc_if

`default_nettype wire

// file: verilog/mcycle_unit.sv
// Machine cycle sequencer: counts clock states and drives the memory bus
`timescale 1ns/1ns
`default_nettype none

module mcycle_unit (
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   reset,
    // Request channel
    mcyc_if.unit        cyc,
    // Memory bus
    input  wire logic [7:0]  mem_rdata,
    output logic [15:0]      mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic             mem_m1,
    output logic [7:0]       mem_wdata
);
    logic        busy_r,  busy_nxt;
    logic [2:0]  tcnt_r,  tcnt_nxt;
    logic [2:0]  len_r,   len_nxt;
    logic [15:0] addr_r,  addr_nxt;
    logic        rd_r,    rd_nxt;
    logic        wr_r,    wr_nxt;
    logic        m1_r,    m1_nxt;
    logic [7:0]  wdata_r, wdata_nxt;
    logic        accept;

    // Last state lets the next cycle start with no idle state between
    assign cyc.last  = busy_r && (tcnt_r == len_r - 3'h1);
    assign cyc.rdata = mem_rdata;
    assign accept    = cyc.start && (!busy_r || cyc.last);

    always_comb
    begin
        busy_nxt  = busy_r;
        tcnt_nxt  = tcnt_r;
        len_nxt   = len_r;
        addr_nxt  = addr_r;
        rd_nxt    = rd_r;
        wr_nxt    = wr_r;
        m1_nxt    = m1_r;
        wdata_nxt = wdata_r;
        if (accept)
        begin
            busy_nxt  = 1'b1;
            tcnt_nxt  = 3'h0;
            len_nxt   = cyc.len;
            addr_nxt  = cyc.addr;
            rd_nxt    = (cyc.kind == load_pkg::CYC_FETCH) || (cyc.kind == load_pkg::CYC_READ);
            wr_nxt    = (cyc.kind == load_pkg::CYC_WRITE);
            m1_nxt    = (cyc.kind == load_pkg::CYC_FETCH);
            wdata_nxt = cyc.wdata;
        end
        else if (cyc.last)
        begin
            busy_nxt = 1'b0;
            rd_nxt   = 1'b0;
            wr_nxt   = 1'b0;
            m1_nxt   = 1'b0;
        end
        else if (busy_r)
            tcnt_nxt = tcnt_r + 3'h1; // RQ2
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            busy_r  <= 1'b0;
            tcnt_r  <= 3'h0;
            len_r   <= 3'h1;
            addr_r  <= 16'h0000;
            rd_r    <= 1'b0;
            wr_r    <= 1'b0;
            m1_r    <= 1'b0;
            wdata_r <= 8'h00;
        end
        else
        begin
            busy_r  <= busy_nxt;
            tcnt_r  <= tcnt_nxt;
            len_r   <= len_nxt;
            addr_r  <= addr_nxt;
            rd_r    <= rd_nxt;
            wr_r    <= wr_nxt;
            m1_r    <= m1_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    assign mem_addr  = addr_r;
    assign mem_rd    = rd_r;
    assign mem_wr    = wr_r;
    assign mem_m1    = m1_r;
    assign mem_wdata = wdata_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    state_bound_a: assert property (busy_r |-> tcnt_r < len_r) // RQ2
        else $error("state count ran past cycle length");
    fetch_len_a: assert property ($rose(m1_r) |-> m1_r [*4]) // RQ2
        else $error("opcode fetch shorter than four states");

endmodule : mcycle_unit

`default_nettype wire

// file: verilog/eight_bit_load_decoder.sv
// Decode and execution of the eight-bit register and memory load group
`timescale 1ns/1ns
`default_nettype none
`include "load_params.svh"

// Functional notes
// RQ1 - Field codes: A7 B0 C1 D2 E3 H4 L5
// RQ2 - Time counted in machine cycles of states
// RQ3 - Register copy, one cycle of four states
// RQ4 - Immediate byte to register, four plus three
// RQ5 - Read at pointer pair into register, 4+3
// RQ6 - First index plus displacement read, 19 states
// RQ7 - Second index plus displacement read, 19 states
// RQ8 - Register stored at pointer pair, 4+3
// RQ9 - Register stored at first index plus displacement
// RQ10 - Register stored at second index plus displacement
// RQ11 - Status flags never changed by loads
// RQ12 - Opcode fields read MSB left
// RQ13 - Displacement sign-extended, address wraps, index unchanged
module eight_bit_load_decoder (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         reset,
    // Memory bus
    input  wire logic [7:0]   mem_rdata,
    output logic [15:0]       mem_addr,
    output logic              mem_rd,
    output logic              mem_wr,
    output logic              mem_m1,
    output logic [7:0]        mem_wdata,
    // Index registers, read only here
    input  wire logic [15:0]  first_index_register,
    input  wire logic [15:0]  second_index_register,
    // Status flags, owned by the arithmetic side
    input  wire logic         flags_wr,
    input  wire logic [7:0]   flags_wdata,
    output logic [7:0]        flags,
    // Register view and progress
    input  wire logic [2:0]   dbg_sel,
    output logic [7:0]        dbg_data,
    output logic              instr_done,
    output logic              unsupported
);
    mcyc_if cyc ();

    load_pkg::phase_t    phase_r, phase_nxt;
    logic [15:0]         pc_r,    pc_nxt;
    logic [7:0]          regs_r   [0:7];
    logic [7:0]          regs_nxt [0:7];
    logic [2:0]          dst_r,   dst_nxt;
    logic [2:0]          src_r,   src_nxt;
    logic                idx_r,   idx_nxt;
    logic                indexed_r, indexed_nxt;
    logic                store_r, store_nxt;
    logic [7:0]          disp_r,  disp_nxt;
    logic [7:0]          flags_r, flags_nxt;
    logic [7:0]          dbg_r,   dbg_nxt;
    logic                done_r,  fin;
    logic                unsup_r, unsup_nxt;
    logic [4:0]          ins_len_r, ins_len_nxt;
    logic                fetch_next;
    load_pkg::op_class_t cls;
    logic [15:0]         memory_pointer_pair;
    logic [15:0]         idx_base;

    assign memory_pointer_pair = {regs_r[4], regs_r[5]}; // RQ1
    assign idx_base = idx_r ? second_index_register : first_index_register;
    assign cls      = load_pkg::op_class(cyc.rdata); // RQ12

    always_comb
    begin
        phase_nxt   = phase_r;
        pc_nxt      = pc_r;
        regs_nxt    = regs_r;
        dst_nxt     = dst_r;
        src_nxt     = src_r;
        idx_nxt     = idx_r;
        indexed_nxt = indexed_r;
        store_nxt   = store_r;
        disp_nxt    = disp_r;
        fin         = 1'b0;
        unsup_nxt   = 1'b0;
        fetch_next  = 1'b0;
        cyc.start   = 1'b0;
        cyc.kind    = load_pkg::CYC_READ;
        cyc.len     = `ELD_T_READ;
        cyc.addr    = pc_r;
        cyc.wdata   = regs_r[src_r];
        case (phase_r)
            load_pkg::PH_BOOT:
                fetch_next = 1'b1;
            load_pkg::PH_OPCODE:
                if (cyc.last)
                begin
                    indexed_nxt = 1'b0;
                    dst_nxt     = cyc.rdata[5:3]; // RQ1
                    src_nxt     = cyc.rdata[2:0]; // RQ1
                    case (cls)
                        load_pkg::OPC_COPY:
                        begin
                            regs_nxt[cyc.rdata[5:3]] = regs_r[cyc.rdata[2:0]]; // RQ3
                            fin        = 1'b1;
                            fetch_next = 1'b1;
                        end
                        load_pkg::OPC_IMM:
                        begin
                            cyc.start = 1'b1; // RQ4
                            pc_nxt    = pc_r + 16'h0001;
                            phase_nxt = load_pkg::PH_IMM;
                        end
                        load_pkg::OPC_PTR_RD:
                        begin
                            cyc.start = 1'b1;
                            cyc.addr  = memory_pointer_pair; // RQ5
                            phase_nxt = load_pkg::PH_MEMRD;
                        end
                        load_pkg::OPC_PTR_WR:
                        begin
                            cyc.start = 1'b1;
                            cyc.kind  = load_pkg::CYC_WRITE;
                            cyc.len   = `ELD_T_WRITE;
                            cyc.addr  = memory_pointer_pair; // RQ8
                            cyc.wdata = regs_r[cyc.rdata[2:0]];
                            phase_nxt = load_pkg::PH_MEMWR;
                        end
                        load_pkg::OPC_PREFIX:
                        begin
                            idx_nxt     = (cyc.rdata == `ELD_PREFIX_TWO); // RQ7
                            indexed_nxt = 1'b1;
                            fetch_next  = 1'b1;
                        end
                        default:
                        begin
                            unsup_nxt  = 1'b1;
                            fin        = 1'b1;
                            fetch_next = 1'b1;
                        end
                    endcase
                end
            load_pkg::PH_PREOP:
                if (cyc.last)
                begin
                    dst_nxt = cyc.rdata[5:3];
                    src_nxt = cyc.rdata[2:0];
                    if (cls == load_pkg::OPC_PTR_RD || cls == load_pkg::OPC_PTR_WR)
                    begin
                        store_nxt = (cls == load_pkg::OPC_PTR_WR); // RQ9 RQ10
                        cyc.start = 1'b1;
                        pc_nxt    = pc_r + 16'h0001;
                        phase_nxt = load_pkg::PH_DISP;
                    end
                    else
                    begin
                        // Other prefixed codes belong to other groups
                        unsup_nxt  = 1'b1;
                        fin        = 1'b1;
                        fetch_next = 1'b1;
                    end
                end
            load_pkg::PH_DISP:
                if (cyc.last)
                begin
                    disp_nxt  = cyc.rdata;
                    cyc.start = 1'b1;
                    cyc.kind  = load_pkg::CYC_CALC;
                    cyc.len   = `ELD_T_CALC; // RQ6
                    phase_nxt = load_pkg::PH_CALC;
                end
            load_pkg::PH_CALC:
                if (cyc.last)
                begin
                    cyc.start = 1'b1;
                    cyc.addr  = load_pkg::eff_addr(idx_base, disp_r); // RQ13
                    if (store_r)
                    begin
                        cyc.kind  = load_pkg::CYC_WRITE;
                        cyc.len   = `ELD_T_WRITE;
                        phase_nxt = load_pkg::PH_MEMWR; // RQ9 RQ10
                    end
                    else
                        phase_nxt = load_pkg::PH_MEMRD; // RQ6 RQ7
                end
            load_pkg::PH_IMM, load_pkg::PH_MEMRD:
                if (cyc.last)
                begin
                    regs_nxt[dst_r] = cyc.rdata; // RQ4 RQ5 RQ6
                    fin             = 1'b1;
                    fetch_next      = 1'b1;
                end
            load_pkg::PH_MEMWR:
                if (cyc.last)
                begin
                    fin        = 1'b1;
                    fetch_next = 1'b1;
                end
            default:
                phase_nxt = load_pkg::PH_BOOT;
        endcase
        if (fetch_next)
        begin
            cyc.start = 1'b1;
            cyc.kind  = load_pkg::CYC_FETCH;
            cyc.len   = `ELD_T_FETCH; // RQ2
            cyc.addr  = pc_r;
            pc_nxt    = pc_r + 16'h0001;
            phase_nxt = (phase_r == load_pkg::PH_OPCODE && cls == load_pkg::OPC_PREFIX)
                        ? load_pkg::PH_PREOP : load_pkg::PH_OPCODE;
        end
        // Loads leave flags alone; only the arithmetic side writes them
        flags_nxt   = flags_wr ? flags_wdata : flags_r; // RQ11
        dbg_nxt     = regs_r[dbg_sel];
        ins_len_nxt = (fin || phase_r == load_pkg::PH_BOOT) ? 5'h01 : ins_len_r + 5'h01;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            phase_r   <= load_pkg::PH_BOOT;
            pc_r      <= `ELD_PC_RESET;
            for (int i = 0; i < 8; i++)
                regs_r[i] <= `ELD_REG_RESET;
            dst_r     <= 3'h0;
            src_r     <= 3'h0;
            idx_r     <= 1'b0;
            indexed_r <= 1'b0;
            store_r   <= 1'b0;
            disp_r    <= 8'h00;
            flags_r   <= `ELD_FLAGS_RESET;
            dbg_r     <= 8'h00;
            done_r    <= 1'b0;
            unsup_r   <= 1'b0;
            ins_len_r <= 5'h01;
        end
        else
        begin
            phase_r   <= phase_nxt;
            pc_r      <= pc_nxt;
            regs_r    <= regs_nxt;
            dst_r     <= dst_nxt;
            src_r     <= src_nxt;
            idx_r     <= idx_nxt;
            indexed_r <= indexed_nxt;
            store_r   <= store_nxt;
            disp_r    <= disp_nxt;
            flags_r   <= flags_nxt;
            dbg_r     <= dbg_nxt;
            done_r    <= fin;
            unsup_r   <= unsup_nxt;
            ins_len_r <= ins_len_nxt;
        end
    end

    mcycle_unit u_cycle (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .cyc       (cyc.unit),
        .mem_rdata (mem_rdata),
        .mem_addr  (mem_addr),
        .mem_rd    (mem_rd),
        .mem_wr    (mem_wr),
        .mem_m1    (mem_m1),
        .mem_wdata (mem_wdata)
    );

    assign flags       = flags_r;
    assign dbg_data    = dbg_r;
    assign instr_done  = done_r;
    assign unsupported = unsup_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic copy_hit;
    logic [7:0] copy_val;
    assign copy_hit = phase_r == load_pkg::PH_OPCODE && cyc.last && cls == load_pkg::OPC_COPY;
    assign copy_val = regs_r[cyc.rdata[2:0]];

    copy_timing_a: assert property (copy_hit |-> ins_len_r == `ELD_LEN_COPY) // RQ3
        else $error("register copy not four states");
    copy_data_a: assert property (copy_hit |=> regs_r[$past(dst_nxt)] == $past(copy_val)) // RQ3
        else $error("register copy wrong value");
    logic mem_end;
    assign mem_end = (phase_r == load_pkg::PH_MEMRD || phase_r == load_pkg::PH_MEMWR)
                     && cyc.last;

    imm_timing_a: assert property (phase_r == load_pkg::PH_IMM && cyc.last // RQ4
        |-> ins_len_r == `ELD_LEN_TWO)
        else $error("immediate load not seven states");
    ptr_timing_a: assert property (mem_end && !indexed_r |-> ins_len_r == `ELD_LEN_TWO) // RQ5
        else $error("pointer access not seven states");
    index_timing_a: assert property (mem_end && indexed_r |-> ins_len_r == `ELD_LEN_INDEX) // RQ6
        else $error("indexed access not nineteen states");
    ptr_addr_a: assert property (phase_r == load_pkg::PH_OPCODE && cyc.last // RQ5
        && (cls == load_pkg::OPC_PTR_RD || cls == load_pkg::OPC_PTR_WR)
        |=> mem_addr == $past(memory_pointer_pair))
        else $error("pointer address wrong");
    index_addr_a: assert property (phase_r == load_pkg::PH_CALC && cyc.last // RQ13
        |=> mem_addr == load_pkg::eff_addr($past(idx_base), $past(disp_r)))
        else $error("indexed address wrong");
    store_data_a: assert property (mem_wr |-> mem_wdata == regs_r[src_r]) // RQ8
        else $error("stored byte differs from register");
    flags_hold_a: assert property (!flags_wr |=> $stable(flags_r)) // RQ11
        else $error("flags changed by a load");

    copy_seen_c: cover property (copy_hit);
    index_store_c: cover property (phase_r == load_pkg::PH_MEMWR && cyc.last && indexed_r && idx_r);
    index_read_c: cover property (phase_r == load_pkg::PH_MEMRD && cyc.last && indexed_r && !idx_r);
    imm_seen_c: cover property (phase_r == load_pkg::PH_IMM && cyc.last);

endmodule : eight_bit_load_decoder

`default_nettype wire

// file: sim/mem_model.sv
// Program and data memory model on the far side of the decoder bus
`timescale 1ns/1ns
`default_nettype none

module mem_model (
    // Clock
    input  wire logic        clk_sys,
    // Bus from the decoder
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [7:0]  mem_wdata,
    output logic [7:0]       mem_rdata
);
    logic [7:0] ram [0:65535];
    logic [7:0] last_r = 8'h00;

    // Released bus shows the inverse of the last byte, so stale data never passes
    assign mem_rdata = mem_rd ? ram[mem_addr] : ~last_r;

    // Plain always: the bench preloads the array between runs
    always @(posedge clk_sys)
    begin
        if (mem_rd)
            last_r <= ram[mem_addr];
        if (mem_wr)
            ram[mem_addr] <= mem_wdata;
    end
endmodule : mem_model

`default_nettype wire

// file: sim/eight_bit_load_decoder_tb.sv
// Self-checking bench for the eight-bit load decoder
`timescale 1ns/1ns
`default_nettype none

module eight_bit_load_decoder_tb;
    logic        clk_sys               = 1'b0;
    logic        reset                 = 1'b1;
    logic [15:0] first_index_register  = 16'h0000;
    logic [15:0] second_index_register = 16'h0000;
    logic        flags_wr              = 1'b0;
    logic [7:0]  flags_wdata           = 8'h00;
    logic [2:0]  dbg_sel               = 3'h0;
    logic [7:0]  mem_rdata;
    logic [15:0] mem_addr;
    logic        mem_rd;
    logic        mem_wr;
    logic        mem_m1;
    logic [7:0]  mem_wdata;
    logic [7:0]  flags;
    logic [7:0]  dbg_data;
    logic        instr_done;
    logic        unsupported;
    int          n_errors              = 0;
    int          tests_run             = 0;
    int          n_unsup;
    int          gap[$];
    logic [7:0]  code[$];

    always #4 clk_sys = ~clk_sys;

    eight_bit_load_decoder dut (.clk_sys, .reset, .mem_rdata, .mem_addr, .mem_rd,
        .mem_wr, .mem_m1, .mem_wdata, .first_index_register, .second_index_register,
        .flags_wr, .flags_wdata, .flags, .dbg_sel, .dbg_data, .instr_done, .unsupported);

    mem_model mem (.clk_sys, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);

    task automatic finish_test();
        $display("Checks: %0d, errors: %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // Reset, load the program at address 0, release
    task automatic start(input int hold, input logic [15:0] ix, input logic [15:0] iy);
        int i;
        @(posedge clk_sys);
        reset <= 1'b1;
        first_index_register <= ix;
        second_index_register <= iy;
        repeat (2) @(posedge clk_sys);
        for (i = 0; i < 65536; i++)
            mem.ram[i] = 8'h00;
        foreach (code[j])
            mem.ram[j] = code[j];
        repeat (hold) @(posedge clk_sys);
        chk("reset address", 16'h0000, mem_addr);
        chk("reset strobes", 16'h0000, {13'h0000, mem_rd, mem_wr, mem_m1});
        chk("reset flags", 16'h0000, {8'h00, flags});
        reset <= 1'b0;
    endtask : start

    // Wait for n completions; gap[k] holds the states of instruction k for k >= 1, gap[0] the cycles up to the first
    task automatic run(input int n);
        int k;
        int t;
        int c;
        k = 0;
        c = 0;
        n_unsup = 0;
        gap.delete();
        for (t = 0; t < 4000 && k < n; t++)
        begin
            @(negedge clk_sys);
            c++;
            if (instr_done === 1'b1)
            begin
                gap.push_back(c);
                c = 0;
                k++;
                if (unsupported === 1'b1)
                    n_unsup++;
            end
        end
        if (k < n)
        begin
            n_errors++;
            $display("Error completion wait: expected %0d, seen %0d", n, k);
            finish_test();
        end
    endtask : run

    // Register view lags the select by one cycle
    task automatic chk_reg(input logic [2:0] sel, input logic [7:0] exp);
        @(posedge clk_sys);
        dbg_sel <= sel;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk("register view", {8'h00, exp}, {8'h00, dbg_data});
    endtask : chk_reg

    task automatic imm_and_copy();
        logic [7:0] exp [8];
        int         i;
        code = '{8'h00, 8'h06, 8'h11, 8'h0E, 8'h22, 8'h16, 8'h33, 8'h1E, 8'h44, 8'h26,
                 8'h55, 8'h2E, 8'h66, 8'h3E, 8'h77, 8'h78, 8'h4A, 8'h63, 8'h45};
        exp = '{8'h66, 8'h33, 8'h33, 8'h44, 8'h44, 8'h66, 8'h00, 8'h11};
        start(16, 16'h0000, 16'h0000);
        run(12);
        for (i = 1; i < 8; i++)
            chk("immediate states", 16'h0007, 16'(gap[i]));
        for (i = 8; i < 12; i++)
            chk("copy states", 16'h0004, 16'(gap[i]));
        for (i = 0; i < 8; i++)
            chk_reg(3'(i), exp[i]);
    endtask : imm_and_copy

    task automatic pointer_ops();
        code = '{8'h00, 8'h26, 8'h12, 8'h2E, 8'h34, 8'h4E, 8'h1E, 8'h9C, 8'h2E, 8'h35, 8'h73};
        start(2, 16'h0000, 16'h0000);
        mem.ram[16'h1234] = 8'h5A;
        run(7);
        chk("pointer read states", 16'h0007, 16'(gap[3]));
        chk("pointer store states", 16'h0007, 16'(gap[6]));
        chk_reg(3'h1, 8'h5A);
        chk("stored byte", 16'h009C, {8'h00, mem.ram[16'h1235]});
        chk("untouched byte", 16'h005A, {8'h00, mem.ram[16'h1234]});
    endtask : pointer_ops

    // Positive displacement wraps past FFFF; negative one reaches below the base
    task automatic indexed_ops();
        code = '{8'h00, 8'h06, 8'hC3, 8'hDD, 8'h4E, 8'h20, 8'hFD, 8'h56, 8'h80,
                 8'hDD, 8'h70, 8'h21, 8'hFD, 8'h71, 8'hFF};
        start(2, 16'hFFF0, 16'h0100);
        mem.ram[16'h0010] = 8'hA7;
        mem.ram[16'h0080] = 8'h96;
        run(6);
        chk("first index read states", 16'h0013, 16'(gap[2]));
        chk("second index read states", 16'h0013, 16'(gap[3]));
        chk("first index store states", 16'h0013, 16'(gap[4]));
        chk("second index store states", 16'h0013, 16'(gap[5]));
        chk_reg(3'h1, 8'hA7);
        chk_reg(3'h2, 8'h96);
        chk("first index store", 16'h00C3, {8'h00, mem.ram[16'h0011]});
        chk("second index store", 16'h00A7, {8'h00, mem.ram[16'h00FF]});
    endtask : indexed_ops

    // Flags loaded from outside must survive a mix of loads and foreign opcodes
    task automatic flags_hold();
        code = '{8'h00, 8'h76, 8'h26, 8'h5A, 8'h46, 8'h71, 8'hDD, 8'h46, 8'h01,
                 8'hDD, 8'h00};
        start(2, 16'h0200, 16'h0000);
        mem.ram[16'h5A00] = 8'h3C;
        mem.ram[16'h0201] = 8'hE7;
        @(posedge clk_sys);
        flags_wr <= 1'b1;
        flags_wdata <= 8'hA5;
        @(posedge clk_sys);
        flags_wr <= 1'b0;
        run(7);
        chk("foreign opcode states", 16'h0004, 16'(gap[1]));
        chk("prefixed foreign states", 16'h0008, 16'(gap[6]));
        chk("foreign opcode count", 16'h0003, 16'(n_unsup));
        chk("flags after loads", 16'h00A5, {8'h00, flags});
        chk("pointer store", 16'h0000, {8'h00, mem.ram[16'h5A00]});
        chk_reg(3'h0, 8'hE7);
    endtask : flags_hold

    initial
    begin
        imm_and_copy();
        pointer_ops();
        indexed_ops();
        flags_hold();
        finish_test();
    end
endmodule : eight_bit_load_decoder_tb

`default_nettype wire
